// File: sram_pkg.sv
// shared constants and carrier types for the burst static memory block
package sram_pkg;

    // array geometry
    localparam int ADDR_W = 20;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int BURST_W = 2;
    localparam int PADDR_W = 8;

    // register byte offsets
    localparam logic [PADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [PADDR_W-1:0] STATUS_OFS = 8'h04;
    localparam logic [PADDR_W-1:0] WRITES_OFS = 8'h08;

    // field positions
    localparam int CTRL_WPROT_BIT = 0;
    localparam int STATUS_SLEEP_BIT = 0;
    localparam int STATUS_ORDER_BIT = 1;
    localparam int STATUS_SEL_BIT = 2;
    localparam int STATUS_STALL_BIT = 3;

    // reset values
    localparam logic CTRL_WPROT_RST = 1'b0;
    localparam logic [31:0] WRITES_RST = 32'h0000_0000;

    // burst order strap encoding
    localparam logic ORDER_LINEAR = 1'b0;
    localparam logic ORDER_INTERLEAVED = 1'b1;

    typedef enum logic [1:0] {
        PHASE_RUN = 2'b01,
        PHASE_SLEEP = 2'b10
    } phase_type;

    // one command held in the pipeline
    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lane_en;
    } cmd_type;

    // synchronous command pins as sampled at the rising edge
    typedef struct packed {
        logic chip_select_low_a;
        logic chip_select_high;
        logic chip_select_low_b;
        logic clock_qualify_n;
        logic advance;
        logic write_n;
        logic [LANES-1:0] lane_n;
        logic out_en_n;
        logic [ADDR_W-1:0] addr;
    } sram_cmd_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [PADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_type;

endpackage

// File: sram_store.sv
// storage array with byte-lane writes and combinational read
`timescale 1ns/10ps
module sram_store #(
    parameter int ADDR_W = 20,
    parameter int LANES = 4,
    parameter int LANE_W = 9
) (
    // clock
    input wire logic clk_in,
    // write port
    input wire logic wr_en_in,
    input wire logic [ADDR_W-1:0] wr_addr_in,
    input wire logic [LANES-1:0] lane_en_in,
    input wire logic [LANES*LANE_W-1:0] wr_data_in,
    // read port
    input wire logic [ADDR_W-1:0] rd_addr_in,
    output logic [LANES*LANE_W-1:0] rd_data_out
);

    logic [LANE_W-1:0] mem [2**ADDR_W][LANES];

    // contents have no reset, as in a real static array
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < LANES; i++) begin
            if (wr_en_in && lane_en_in[i]) begin
                mem[wr_addr_in][i] <= wr_data_in[i*LANE_W +: LANE_W];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            rd_data_out[i*LANE_W +: LANE_W] = mem[rd_addr_in][i];
        end
    end

endmodule

// File: sram_burst_top.sv
// pipelined burst static memory with sleep mode and an apb status port
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/10ps

// Operation
// - selected only when low, high, low
// - strap 0 linear burst, 1 interleaved
// - qualify high: edge ignored, no write
// - data pins undriven on leaving sleep
module sram_burst_top
    import sram_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic RST_B_IN,
    // register bus
    input wire apb_req_type APB_REQ_IN,
    output apb_rsp_type APB_RSP_OUT,
    // memory command pins
    input wire sram_cmd_type SRAM_CMD_IN,
    input wire logic SLEEP_REQUEST_IN,
    input wire logic BURST_ORDER_IN,
    // data pins
    input wire logic [DATA_W-1:0] DQ_IN,
    output logic [DATA_W-1:0] DQ_OUT,
    output logic DQ_OE_OUT
);

    typedef struct packed {
        phase_type phase;
        logic [1:0] sleep_sync;
        logic [1:0] order_sync;
        cmd_type cmd_a;
        cmd_type cmd_b;
        logic [BURST_W-1:0] burst_base;
        logic [BURST_W-1:0] burst_cnt;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
        logic wprot;
        logic last_sel;
        logic last_stall;
        logic [31:0] writes;
        apb_rsp_type rsp;
    } top_state_type;

    localparam top_state_type STATE_RST = '{
        phase: PHASE_RUN,
        sleep_sync: 2'h0,
        order_sync: 2'h0,
        cmd_a: '0,
        cmd_b: '0,
        burst_base: '0,
        burst_cnt: '0,
        dq_out: '0,
        dq_oe: 1'b0,
        wprot: CTRL_WPROT_RST,
        last_sel: 1'b0,
        last_stall: 1'b0,
        writes: WRITES_RST,
        rsp: '0
    };

    top_state_type s_q;
    top_state_type s_d;
    logic [DATA_W-1:0] rd_data;
    logic wr_go;
    logic stall;
    logic asleep;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic is_selected(input sram_cmd_type c);
        return !c.chip_select_low_a && c.chip_select_high && !c.chip_select_low_b;
    endfunction

    function automatic logic [BURST_W-1:0] burst_offset(input logic [BURST_W-1:0] base,
                                                       input logic [BURST_W-1:0] cnt,
                                                       input logic order);
        if (order == ORDER_INTERLEAVED) begin
            return base ^ cnt;
        end else begin
            return base + cnt;
        end
    endfunction

    function automatic logic [31:0] read_reg(input logic [PADDR_W-1:0] a, input top_state_type s);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == CTRL_OFS) begin
            v[CTRL_WPROT_BIT] = s.wprot;
        end else if (a == STATUS_OFS) begin
            v[STATUS_SLEEP_BIT] = (s.phase == PHASE_SLEEP);
            v[STATUS_ORDER_BIT] = s.order_sync[1];
            v[STATUS_SEL_BIT] = s.last_sel;
            v[STATUS_STALL_BIT] = s.last_stall;
        end else if (a == WRITES_OFS) begin
            v = s.writes;
        end
        return v;
    endfunction

    function automatic logic is_mapped(input logic [PADDR_W-1:0] a);
        return (a == CTRL_OFS) || (a == STATUS_OFS) || (a == WRITES_OFS);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // storage

    // read and write share the cmd_b address: a read right behind a write
    // to the same word is looked up after that write has landed
    sram_store #(
        .ADDR_W(ADDR_W),
        .LANES(LANES),
        .LANE_W(LANE_W)
    ) store (
        .clk_in(SYS_CLK_IN),
        .wr_en_in(wr_go),
        .wr_addr_in(s_q.cmd_b.addr),
        .lane_en_in(s_q.cmd_b.lane_en),
        .wr_data_in(DQ_IN),
        .rd_addr_in(s_q.cmd_b.addr),
        .rd_data_out(rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    // sleep and strap pins are not tied to our clock, so only the second stage is used
    assign asleep = s_q.sleep_sync[1];
    // qualify comes from the controller on our own clock, so no synchroniser delays it
    assign stall = SRAM_CMD_IN.clock_qualify_n;
    // write data arrives two edges after its address, so cmd_b commits now
    assign wr_go = (s_q.phase == PHASE_RUN) && !asleep && !stall &&
                   s_q.cmd_b.valid && s_q.cmd_b.write && !s_q.wprot;

    always_comb begin
        s_d = s_q;
        s_d.sleep_sync = {s_q.sleep_sync[0], SLEEP_REQUEST_IN};
        s_d.order_sync = {s_q.order_sync[0], BURST_ORDER_IN};

        case (s_q.phase)
            PHASE_RUN: begin
                if (asleep) begin
                    // entry assumes the controller already deselected us; anything in flight is dropped
                    s_d.phase = PHASE_SLEEP;
                    s_d.cmd_a = '0;
                    s_d.cmd_b = '0;
                    s_d.dq_oe = 1'b0;
                end else if (stall) begin
                    // the whole pipeline and the data pins hold as if the edge never came
                    s_d.last_stall = 1'b1;
                end else begin
                    s_d.last_stall = 1'b0;
                    if (SRAM_CMD_IN.advance) begin
                        if (s_q.cmd_a.valid) begin
                            s_d.burst_cnt = s_q.burst_cnt + 2'h1;
                            s_d.cmd_a.addr[BURST_W-1:0] = burst_offset(s_q.burst_base, s_d.burst_cnt,
                                                                       s_q.order_sync[1]);
                            s_d.cmd_a.lane_en = ~SRAM_CMD_IN.lane_n;
                        end
                    end else begin
                        s_d.last_sel = is_selected(SRAM_CMD_IN);
                        s_d.cmd_a.valid = is_selected(SRAM_CMD_IN);
                        s_d.cmd_a.write = !SRAM_CMD_IN.write_n;
                        s_d.cmd_a.addr = SRAM_CMD_IN.addr;
                        s_d.cmd_a.lane_en = ~SRAM_CMD_IN.lane_n;
                        s_d.burst_base = SRAM_CMD_IN.addr[BURST_W-1:0];
                        s_d.burst_cnt = '0;
                    end
                    s_d.cmd_b = s_q.cmd_a;
                    s_d.dq_out = rd_data;
                    s_d.dq_oe = s_q.cmd_b.valid && !s_q.cmd_b.write && !SRAM_CMD_IN.out_en_n;
                end
            end
            PHASE_SLEEP: begin
                // waking does not revive the old pipeline; pins stay off until a fresh read
                s_d.cmd_a = '0;
                s_d.cmd_b = '0;
                s_d.dq_oe = 1'b0;
                if (!asleep) begin
                    s_d.phase = PHASE_RUN;
                end
            end
            default: begin
                s_d.phase = PHASE_SLEEP;
            end
        endcase

        if (wr_go) begin
            s_d.writes = s_q.writes + 32'h0000_0001;
        end

        // answer one cycle into the access phase so every bus output is a flop
        s_d.rsp.pready = 1'b0;
        if (APB_REQ_IN.psel && APB_REQ_IN.penable && !s_q.rsp.pready) begin
            s_d.rsp.pready = 1'b1;
            s_d.rsp.pslverr = !is_mapped(APB_REQ_IN.paddr);
            s_d.rsp.prdata = APB_REQ_IN.pwrite ? 32'h0000_0000 : read_reg(APB_REQ_IN.paddr, s_q);
        end
        // a write lands only at the edge where the master sees pready, never earlier
        if (APB_REQ_IN.psel && APB_REQ_IN.penable && s_q.rsp.pready && APB_REQ_IN.pwrite) begin
            if (APB_REQ_IN.paddr == CTRL_OFS) begin
                s_d.wprot = APB_REQ_IN.pwdata[CTRL_WPROT_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign APB_RSP_OUT = s_q.rsp;
    assign DQ_OUT = s_q.dq_out;
    assign DQ_OE_OUT = s_q.dq_oe;

endmodule

// File: sram_burst_properties.sv
// port-level checks on the burst memory block
`timescale 1ns/10ps
module sram_burst_properties
    import sram_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic RST_B_IN,
    input wire apb_req_type APB_REQ_IN,
    input wire apb_rsp_type APB_RSP_OUT,
    input wire sram_cmd_type SRAM_CMD_IN,
    input wire logic SLEEP_REQUEST_IN,
    input wire logic BURST_ORDER_IN,
    input wire logic [DATA_W-1:0] DQ_IN,
    input wire logic [DATA_W-1:0] DQ_OUT,
    input wire logic DQ_OE_OUT
);
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    logic [2:0] awake_q;
    // margin for the sleep synchroniser before commands count
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            awake_q <= 3'h0;
        end else if (SLEEP_REQUEST_IN) begin
            awake_q <= 3'h0;
        end else if (awake_q != 3'h7) begin
            awake_q <= awake_q + 3'h1;
        end
    end
    wire run = !SRAM_CMD_IN.clock_qualify_n && awake_q > 3'h3;
    wire sel = !SRAM_CMD_IN.chip_select_low_a && SRAM_CMD_IN.chip_select_high && !SRAM_CMD_IN.chip_select_low_b;
    sequence s_desel;
        run && !SRAM_CMD_IN.advance && !sel;
    endsequence
    sequence s_read;
        run && !SRAM_CMD_IN.advance && sel && SRAM_CMD_IN.write_n;
    endsequence
    a_desel_quiet: assert property (s_desel ##1 run ##1 run |=> !DQ_OE_OUT)
        else $error("deselected load drove the data pins");
    a_read_drives: assert property (s_read ##1 run ##1 (run && !SRAM_CMD_IN.out_en_n) |=> DQ_OE_OUT)
        else $error("selected read left the data pins undriven");
    a_stall_holds: assert property (SRAM_CMD_IN.clock_qualify_n && awake_q > 3'h3 |=>
        $stable(DQ_OUT) && $stable(DQ_OE_OUT))
        else $error("stalled edge changed the data pins");
    a_sleep_quiet: assert property (SLEEP_REQUEST_IN [*3] |=> !DQ_OE_OUT)
        else $error("data pins driven while asleep");
    a_wake_quiet: assert property (SLEEP_REQUEST_IN [*3] ##1 !SLEEP_REQUEST_IN |-> !DQ_OE_OUT [*4])
        else $error("data pins driven right after waking");
endmodule
bind sram_burst_top sram_burst_properties u_props (.SYS_CLK_IN, .RST_B_IN, .APB_REQ_IN, .APB_RSP_OUT,
    .SRAM_CMD_IN, .SLEEP_REQUEST_IN, .BURST_ORDER_IN, .DQ_IN, .DQ_OUT, .DQ_OE_OUT);

// File: sram_ctrl_model.sv
// memory controller model driving command, sleep and data pins
`timescale 1ns/10ps
module sram_ctrl_model
    import sram_pkg::*;
(
    input wire logic clk_in,
    output sram_cmd_type cmd_out,
    output logic sleep_out,
    output logic [DATA_W-1:0] dq_out
);
    logic [DATA_W-1:0] d_cur = '0;
    logic [DATA_W-1:0] d_a = '0;
    initial begin
        cmd_out = '1;
        sleep_out = 1'b0;
        dq_out = '0;
    end
    // write data lands two taken edges after its command; a stall freezes it
    always @(posedge clk_in) begin
        if (!cmd_out.clock_qualify_n) begin
            d_a <= d_cur;
            dq_out <= d_a;
        end
    end
    // select bits are low_a, high, low_b; idle data toggles so stale values never match
    task automatic op(input logic [2:0] s, input logic q, adv, wn, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        cmd_out <= {s, q, adv, wn, 4'h0, 1'b0, a};
        d_cur <= wn ? ~d_a : d;
    endtask
    task automatic sleep(input logic v);
        @(posedge clk_in);
        cmd_out.chip_select_low_a <= 1'b1;
        sleep_out <= v;
    endtask
endmodule

// File: sram_burst_top_bench.sv
// self-checking bench for the burst memory block
`timescale 1ns/10ps
module sram_burst_top_bench
    import sram_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic order = ORDER_LINEAR;
    apb_req_type req = '0;
    apb_rsp_type rsp;
    sram_cmd_type cmd;
    logic sleep;
    logic [DATA_W-1:0] dq_in;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
    logic [31:0] rd;
    int failures = 0;
    int tests_run = 0;
    localparam logic [2:0] SEL = 3'b010;
    localparam logic [2:0] DES = 3'b110;
    initial forever #5 clk = ~clk;
    sram_ctrl_model m (.clk_in(clk), .cmd_out(cmd), .sleep_out(sleep), .dq_out(dq_in));
    sram_burst_top dut (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .APB_REQ_IN(req), .APB_RSP_OUT(rsp), .SRAM_CMD_IN(cmd),
        .SLEEP_REQUEST_IN(sleep), .BURST_ORDER_IN(order), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE_OUT(dq_oe));
    task automatic summarize();
        $display("%0d checks, %0d failures", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        for (n = 0; n < 20 && rsp.pready !== 1'b1; n++) @(posedge clk);
        if (n == 20) begin
            failures++;
            summarize();
        end else begin
            rd = rsp.pslverr ? 32'hdead : rsp.prdata;
            req <= '0;
        end
    endtask
    // after each command the data of the command three calls back is on the pins
    task automatic step(input logic [2:0] s, input logic q, adv, wn, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input logic c, input logic [DATA_W-1:0] e);
        m.op(s, q, adv, wn, a, d);
        #1;
        if (c) begin
            check(dq_out, e);
            check(dq_oe, 1'b1);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) step(DES, 1'b0, 1'b0, 1'b1, '0, '0, 1'b0, '0);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        apb(8'h0c, 1'b0, 32'h0);
        check(rd, 32'hdead);
        for (int i = 0; i < 4; i++) step(SEL, 1'b0, 1'b0, 1'b0, 20'(16 + i), {4{9'(i + 7)}}, 1'b0, '0);
        for (int i = 0; i < 8; i++) if (3'(i) != SEL) step(3'(i), 1'b0, 1'b0, 1'b0, 20'h10, '1, 1'b0, '0);
        step(SEL, 1'b1, 1'b0, 1'b0, 20'h11, '1, 1'b0, '0);
        for (int o = 0; o < 2; o++) begin
            @(posedge clk);
            order <= o[0];
            idle(4);
            step(SEL, 1'b0, 1'b0, 1'b1, 20'h11, '0, 1'b0, '0);
            for (int k = 1; k < 7; k++) step(k < 4 ? SEL : DES, 1'b0, k < 4, 1'b1, '0, '0, k > 2,
                {4{9'(7 + (o ? (1 ^ (k - 3)) : ((k - 2) % 4)))}});
        end
        apb(WRITES_OFS, 1'b0, 32'h0);
        check(rd, 32'h4);
        // write protect on: a selected write must leave the word and the count alone
        apb(CTRL_OFS, 1'b1, 32'h1);
        apb(CTRL_OFS, 1'b0, 32'h0);
        check(rd[CTRL_WPROT_BIT], 1'b1);
        step(SEL, 1'b0, 1'b0, 1'b0, 20'h12, '1, 1'b0, '0);
        idle(3);
        apb(CTRL_OFS, 1'b1, 32'h0);
        apb(WRITES_OFS, 1'b0, 32'h0);
        check(rd, 32'h4);
        m.sleep(1'b1);
        repeat (4) @(posedge clk);
        apb(STATUS_OFS, 1'b0, 32'h0);
        check(rd[STATUS_SLEEP_BIT], 1'b1);
        check(rd[STATUS_ORDER_BIT], ORDER_INTERLEAVED);
        check(dq_oe, 1'b0);
        m.sleep(1'b0);
        idle(5);
        check(dq_oe, 1'b0);
        step(SEL, 1'b0, 1'b0, 1'b1, 20'h12, '0, 1'b0, '0);
        idle(2);
        step(DES, 1'b0, 1'b0, 1'b1, '0, '0, 1'b1, {4{9'h9}});
        summarize();
    end
endmodule
